// *** phy_ctrl_pkg.sv ***
package phy_ctrl_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] BASIC_MODE_CONTROL_OFS = 5'h00;
  localparam logic [15:0] READ_NONE = 16'h0000;

  // ==========================================================
  // Field positions in basic_mode_control
  localparam int LOOPBACK_BIT = 14;
  localparam int SPEED_BIT = 13;
  localparam int AN_ENABLE_BIT = 12;
  localparam int POWER_DOWN_BIT = 11;
  localparam int ISOLATE_BIT = 10;
  localparam int AN_RESTART_BIT = 9;
  localparam int DUPLEX_BIT = 8;
  localparam int COL_TEST_BIT = 7;
  localparam int RESERVED_MSB = 6;
  localparam logic [6:0] RESERVED_VAL = 7'h00;

  // ==========================================================
  // Reset values of the plain fields
  localparam logic LOOPBACK_RST = 1'b0;
  localparam logic POWER_DOWN_RST = 1'b0;
  localparam logic ISOLATE_RST = 1'b0;
  localparam logic AN_RESTART_RST = 1'b0;
  localparam logic COL_TEST_RST = 1'b0;

  // ==========================================================
  // Management frame layout
  localparam int PREAMBLE_ONES = 32;
  localparam int HDR_BITS = 13;
  localparam int DATA_BITS = 16;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // ==========================================================
  // Timing, bit time at 100 Mb/s
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_TIME_NS = 10;
  localparam int COL_ON_BITS = 512;
  localparam int COL_OFF_BITS = 4;
  localparam int COL_ON_MAX_CYC = (COL_ON_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int COL_OFF_MAX_CYC = (COL_OFF_BITS * BIT_TIME_NS) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  // Collision path: two sync stages plus the output flop
  localparam int COL_PATH_CYC = SYNC_STAGES + 1;
  localparam int STRAP_WAIT_CYC = SYNC_STAGES;

  typedef enum logic [2:0] {
    MGMT_PREAMBLE,
    MGMT_HEADER,
    MGMT_TURNAROUND,
    MGMT_READ,
    MGMT_WRITE
  } mgmt_state_type;

endpackage : phy_ctrl_pkg

// *** pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync

// *** phy_basic_control.sv ***
`timescale 1ns/1ns
module phy_basic_control #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic MDC,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_N,
  input wire logic SLEEP_REQUEST_PIN_N,
  input wire logic STRAP_AN_ENABLE,
  input wire logic STRAP_SPEED_100,
  input wire logic STRAP_FULL_DUPLEX,
  input wire logic TX_EN,
  input wire logic AN_STARTED,
  output logic COL,
  output logic POWER_DOWN,
  output logic ISOLATE,
  output logic LOOPBACK,
  output logic AN_ENABLE,
  output logic AN_RESTART,
  output logic FORCE_SPEED_100,
  output logic FORCE_FULL_DUPLEX
);

  logic [6:0] pins_s;
  logic mdc_s;
  logic mdio_s;
  logic sleep_n_s;
  logic tx_en_s;
  logic strap_an_s;
  logic strap_speed_s;
  logic strap_duplex_s;
  logic mdc_prev_q;
  logic mdc_rise;

  // ==========================================================
  // Pin synchronisers; sleep pin idles high
  pin_sync #(
    .WIDTH(7),
    .RST_VAL(7'h04)
  ) u_sync (
    .CLK(CLK),
    .RST_N(RST_N),
    .async_in({STRAP_FULL_DUPLEX, STRAP_SPEED_100, STRAP_AN_ENABLE, TX_EN,
               SLEEP_REQUEST_PIN_N, MDIO_I, MDC}),
    .sync_out(pins_s)
  );

  assign mdc_s = pins_s[0];
  assign mdio_s = pins_s[1];
  assign sleep_n_s = pins_s[2];
  assign tx_en_s = pins_s[3];
  assign strap_an_s = pins_s[4];
  assign strap_speed_s = pins_s[5];
  assign strap_duplex_s = pins_s[6];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_prev_q;

  // ==========================================================
  // Management frame engine
  phy_ctrl_pkg::mgmt_state_type state_q;
  logic [5:0] pre_cnt_q;
  logic [3:0] bit_cnt_q;
  logic [11:0] hdr_q;
  logic [15:0] shift_q;
  logic is_read_q;
  logic [4:0] reg_addr_q;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [12:0] hdr_full;
  logic [15:0] rd_data;

  assign hdr_full = {hdr_q, mdio_s};
  assign wr_data = {shift_q[14:0], mdio_s};
  assign wr_stb = mdc_rise && (state_q == phy_ctrl_pkg::MGMT_WRITE) && (bit_cnt_q == 4'hF)
                  && (reg_addr_q == phy_ctrl_pkg::BASIC_MODE_CONTROL_OFS);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= phy_ctrl_pkg::MGMT_PREAMBLE;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 4'h0;
      hdr_q <= 12'h000;
      shift_q <= 16'h0000;
      is_read_q <= 1'b0;
      reg_addr_q <= 5'h00;
      MDIO_O <= 1'b1;
      MDIO_OE_N <= 1'b1;
    end else if (mdc_rise) begin
      case (state_q)
        phy_ctrl_pkg::MGMT_PREAMBLE: begin
          MDIO_OE_N <= 1'b1;
          if (mdio_s) begin
            if (pre_cnt_q != 6'(phy_ctrl_pkg::PREAMBLE_ONES)) begin
              pre_cnt_q <= pre_cnt_q + 6'h01;
            end
          end else if (pre_cnt_q == 6'(phy_ctrl_pkg::PREAMBLE_ONES)) begin
            state_q <= phy_ctrl_pkg::MGMT_HEADER;
            bit_cnt_q <= 4'h0;
            pre_cnt_q <= 6'h00;
          end else begin
            pre_cnt_q <= 6'h00;
          end
        end
        phy_ctrl_pkg::MGMT_HEADER: begin
          hdr_q <= hdr_full[11:0];
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'(phy_ctrl_pkg::HDR_BITS - 1)) begin
            bit_cnt_q <= 4'h0;
            reg_addr_q <= hdr_full[4:0];
            is_read_q <= (hdr_full[11:10] == phy_ctrl_pkg::OP_READ);
            // Wrong start, opcode or address: wait for a fresh preamble
            if (hdr_full[12] && (hdr_full[9:5] == PHY_ADDR)
                && ((hdr_full[11:10] == phy_ctrl_pkg::OP_READ)
                    || (hdr_full[11:10] == phy_ctrl_pkg::OP_WRITE))) begin
              state_q <= phy_ctrl_pkg::MGMT_TURNAROUND;
            end else begin
              state_q <= phy_ctrl_pkg::MGMT_PREAMBLE;
            end
          end
        end
        phy_ctrl_pkg::MGMT_TURNAROUND: begin
          if (bit_cnt_q == 4'h0) begin
            bit_cnt_q <= 4'h1;
            if (is_read_q) begin
              MDIO_O <= 1'b0;
              MDIO_OE_N <= 1'b0;
            end
          end else begin
            bit_cnt_q <= 4'h0;
            if (is_read_q) begin
              MDIO_O <= rd_data[15];
              shift_q <= {rd_data[14:0], 1'b0};
              state_q <= phy_ctrl_pkg::MGMT_READ;
            end else begin
              state_q <= phy_ctrl_pkg::MGMT_WRITE;
            end
          end
        end
        phy_ctrl_pkg::MGMT_READ: begin
          if (bit_cnt_q == 4'hF) begin
            MDIO_OE_N <= 1'b1;
            MDIO_O <= 1'b1;
            state_q <= phy_ctrl_pkg::MGMT_PREAMBLE;
          end else begin
            MDIO_O <= shift_q[15];
            shift_q <= {shift_q[14:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        phy_ctrl_pkg::MGMT_WRITE: begin
          shift_q <= wr_data;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == 4'hF) begin
            state_q <= phy_ctrl_pkg::MGMT_PREAMBLE;
          end
        end
        default: begin
          state_q <= phy_ctrl_pkg::MGMT_PREAMBLE;
          MDIO_OE_N <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Control fields
  logic loopback_q;
  logic speed_q;
  logic an_en_q;
  logic pd_q;
  logic iso_q;
  logic restart_q;
  logic duplex_q;
  logic col_test_q;
  logic [1:0] strap_cnt_q;
  logic strap_load;

  // Straps caught once the synchronisers have settled after reset
  assign strap_load = (strap_cnt_q == 2'(phy_ctrl_pkg::STRAP_WAIT_CYC));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_cnt_q <= 2'h0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      speed_q <= 1'b0;
      an_en_q <= 1'b0;
      duplex_q <= 1'b0;
    end else if (strap_load) begin
      speed_q <= strap_speed_s;
      an_en_q <= strap_an_s;
      duplex_q <= strap_duplex_s;
    end else if (wr_stb) begin
      speed_q <= wr_data[phy_ctrl_pkg::SPEED_BIT];
      an_en_q <= wr_data[phy_ctrl_pkg::AN_ENABLE_BIT];
      duplex_q <= wr_data[phy_ctrl_pkg::DUPLEX_BIT];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      loopback_q <= phy_ctrl_pkg::LOOPBACK_RST;
      iso_q <= phy_ctrl_pkg::ISOLATE_RST;
      col_test_q <= phy_ctrl_pkg::COL_TEST_RST;
    end else if (wr_stb) begin
      loopback_q <= wr_data[phy_ctrl_pkg::LOOPBACK_BIT];
      iso_q <= wr_data[phy_ctrl_pkg::ISOLATE_BIT];
      col_test_q <= wr_data[phy_ctrl_pkg::COL_TEST_BIT];
    end
  end

  // Pin held low keeps the field set, so a clearing write loses
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pd_q <= phy_ctrl_pkg::POWER_DOWN_RST;
    end else if (!sleep_n_s) begin
      pd_q <= 1'b1;
    end else if (wr_stb) begin
      pd_q <= wr_data[phy_ctrl_pkg::POWER_DOWN_BIT];
    end
  end

  // A new request beats the start acknowledge in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      restart_q <= phy_ctrl_pkg::AN_RESTART_RST;
    end else if (wr_stb && wr_data[phy_ctrl_pkg::AN_RESTART_BIT]
                 && wr_data[phy_ctrl_pkg::AN_ENABLE_BIT]) begin
      restart_q <= 1'b1;
    end else if (AN_STARTED) begin
      restart_q <= 1'b0;
    end
  end

  always_comb begin
    if (reg_addr_q == phy_ctrl_pkg::BASIC_MODE_CONTROL_OFS) begin
      rd_data = {1'b0, loopback_q, speed_q, an_en_q, pd_q, iso_q, restart_q, duplex_q,
                 col_test_q, phy_ctrl_pkg::RESERVED_VAL};
    end else begin
      rd_data = phy_ctrl_pkg::READ_NONE;
    end
  end

  // ==========================================================
  // Outputs to the rest of the transceiver
  logic pd_eff;

  assign pd_eff = pd_q | ~sleep_n_s;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      COL <= 1'b0;
      POWER_DOWN <= 1'b0;
      ISOLATE <= 1'b0;
      LOOPBACK <= 1'b0;
      AN_ENABLE <= 1'b0;
      AN_RESTART <= 1'b0;
      FORCE_SPEED_100 <= 1'b0;
      FORCE_FULL_DUPLEX <= 1'b0;
    end else begin
      // Three-cycle path, well inside four bit times
      COL <= col_test_q & tx_en_s & ~pd_eff & ~iso_q;
      POWER_DOWN <= pd_eff;
      ISOLATE <= iso_q | pd_eff;
      LOOPBACK <= loopback_q & ~pd_eff;
      AN_ENABLE <= an_en_q & ~pd_eff;
      // Request held while powered down, issued on wake
      AN_RESTART <= restart_q & an_en_q & ~pd_eff;
      FORCE_SPEED_100 <= speed_q & ~an_en_q;
      FORCE_FULL_DUPLEX <= duplex_q & ~an_en_q;
    end
  end

endmodule : phy_basic_control

// *** phy_basic_control_props.sv ***
`timescale 1ns/1ns
// ==========
// Port checks
module phy_basic_control_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SLEEP_REQUEST_PIN_N,
  input wire logic TX_EN,
  input wire logic AN_STARTED,
  input wire logic MDIO_OE_N,
  input wire logic COL,
  input wire logic POWER_DOWN,
  input wire logic ISOLATE,
  input wire logic AN_ENABLE,
  input wire logic AN_RESTART,
  input wire logic FORCE_FULL_DUPLEX
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  chk_pin_power_down: assert property (!SLEEP_REQUEST_PIN_N [*5] |-> POWER_DOWN)
    else $error("pin low but not powered down");
  chk_down_isolates: assert property (POWER_DOWN [*2] |-> ISOLATE)
    else $error("powered down but not isolated");
  chk_col_cause: assert property (COL |-> $past(TX_EN, 3))
    else $error("collision without transmit enable");
  chk_col_release: assert property ($fell(TX_EN) |-> ##[1:5] !COL)
    else $error("collision held too long");
  chk_isolate_col: assert property (ISOLATE [*4] |-> !COL)
    else $error("collision while isolated");
  chk_restart_clears: assert property (AN_RESTART && AN_STARTED |-> ##[1:2] !AN_RESTART)
    else $error("restart did not clear");
  chk_restart_needs_an: assert property ($rose(AN_RESTART) |-> ##[0:1] AN_ENABLE)
    else $error("restart without negotiation enabled");
  chk_duplex_ignored: assert property (AN_ENABLE [*2] |-> !FORCE_FULL_DUPLEX)
    else $error("manual duplex used during negotiation");
  cover property ($rose(COL));
  cover property ($fell(AN_RESTART));
  cover property ($fell(MDIO_OE_N));
endmodule : phy_basic_control_props

bind phy_basic_control phy_basic_control_props props (.CLK(CLK), .RST_N(RST_N),
  .SLEEP_REQUEST_PIN_N(SLEEP_REQUEST_PIN_N), .TX_EN(TX_EN), .AN_STARTED(AN_STARTED), .MDIO_OE_N(MDIO_OE_N),
  .COL(COL), .POWER_DOWN(POWER_DOWN), .ISOLATE(ISOLATE), .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART),
  .FORCE_FULL_DUPLEX(FORCE_FULL_DUPLEX));

// *** mac_model.sv ***
`timescale 1ns/1ns
// ==========
// Management master, data line pulled up
module mac_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic CLK,
  input wire logic MDIO_O,
  input wire logic MDIO_OE_N,
  output logic MDC,
  output logic MDIO_I
);
  logic m_en = 1'b0;
  logic m_out = 1'b1;
  initial MDC = 1'b0;
  // Nobody driving: pull-up wins
  assign MDIO_I = !MDIO_OE_N ? MDIO_O : (m_en ? m_out : 1'b1);

  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, 2'b01, op, PHY_ADDR, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      // Reads hand the line over at turnaround
      m_en = (op == phy_ctrl_pkg::OP_WRITE) || (i > 17);
      m_out = bits[i];
      repeat (4) @(posedge CLK);
      #1 MDC = 1'b1;
      rd = {rd[14:0], MDIO_I};
      repeat (4) @(posedge CLK);
      #1 MDC = 1'b0;
    end
    m_en = 1'b0;
  endtask : frame
endmodule : mac_model

// *** tb_phy_basic_control.sv ***
`timescale 1ns/1ns
// ==========
// Bench
module tb_phy_basic_control;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic SLEEP_REQUEST_PIN_N = 1'b1;
  logic TX_EN = 1'b0;
  logic AN_STARTED = 1'b0;
  logic STRAP_AN_ENABLE = 1'b1;
  logic STRAP_SPEED_100 = 1'b1;
  logic STRAP_FULL_DUPLEX = 1'b1;
  logic MDC, MDIO_I, MDIO_O, MDIO_OE_N, COL, POWER_DOWN, ISOLATE, AN_ENABLE, AN_RESTART, FORCE_FULL_DUPLEX;
  logic LOOPBACK, FORCE_SPEED_100;
  logic [15:0] seen, junk, w;
  logic [15:0] exp_q[$];
  logic [31:0] lfsr_q = 32'h2AFC;
  int failures = 0;
  int total_checks = 0;
  event got;

  phy_basic_control dut (.CLK(CLK), .RST_N(RST_N), .MDC(MDC), .MDIO_I(MDIO_I), .MDIO_O(MDIO_O),
    .MDIO_OE_N(MDIO_OE_N), .SLEEP_REQUEST_PIN_N(SLEEP_REQUEST_PIN_N), .STRAP_AN_ENABLE(STRAP_AN_ENABLE),
    .STRAP_SPEED_100(STRAP_SPEED_100), .STRAP_FULL_DUPLEX(STRAP_FULL_DUPLEX), .TX_EN(TX_EN),
    .AN_STARTED(AN_STARTED), .COL(COL), .POWER_DOWN(POWER_DOWN), .ISOLATE(ISOLATE), .LOOPBACK(LOOPBACK),
    .AN_ENABLE(AN_ENABLE), .AN_RESTART(AN_RESTART), .FORCE_SPEED_100(FORCE_SPEED_100),
    .FORCE_FULL_DUPLEX(FORCE_FULL_DUPLEX));
  mac_model mac (.CLK(CLK), .MDIO_O(MDIO_O), .MDIO_OE_N(MDIO_OE_N), .MDC(MDC), .MDIO_I(MDIO_I));

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_word(input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected read data: expected %h seen %h", e, s);
    end
  endtask : check_word

  task automatic check_pin(input string n, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", n, e, s);
    end
  endtask : check_pin

  task automatic settle;
    repeat (4) @(posedge CLK);
    #1;
  endtask : settle

  task automatic wr(input logic [15:0] d);
    mac.frame(phy_ctrl_pkg::OP_WRITE, phy_ctrl_pkg::BASIC_MODE_CONTROL_OFS, d, junk);
    settle();
  endtask : wr

  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    mac.frame(phy_ctrl_pkg::OP_READ, ra, 16'h0000, seen);
    ->got;
  endtask : rd

  initial begin
    forever #4 CLK = ~CLK;
  end

  initial begin
    forever begin
      @(got);
      check_word(exp_q.pop_front(), seen);
    end
  end

  initial begin
    repeat (40000) @(posedge CLK);
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge CLK);
    #1 RST_N = 1'b1;
    settle();
    rd(5'h00, 16'h3100);
    check_pin("AN_ENABLE", 1'b1, AN_ENABLE);
    check_pin("FORCE_FULL_DUPLEX", 1'b0, FORCE_FULL_DUPLEX);
    rd(5'h01, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      // Restart written with negotiation off, reserved bits random
      w = {1'b0, lfsr_q[14:13], 4'h1, lfsr_q[8], 1'b1, lfsr_q[6:0]};
      wr(w);
      rd(5'h00, {1'b0, w[14:13], 4'h0, w[8], 8'h80});
      check_pin("FORCE_FULL_DUPLEX", w[8], FORCE_FULL_DUPLEX);
      check_pin("FORCE_SPEED_100", w[13], FORCE_SPEED_100);
      check_pin("LOOPBACK", w[14], LOOPBACK);
      check_pin("AN_RESTART", 1'b0, AN_RESTART);
    end
    TX_EN = 1'b1;
    settle();
    check_pin("COL", 1'b1, COL);
    TX_EN = 1'b0;
    settle();
    check_pin("COL", 1'b0, COL);
    wr(16'h0480);
    rd(5'h00, 16'h0480);
    check_pin("ISOLATE", 1'b1, ISOLATE);
    TX_EN = 1'b1;
    settle();
    check_pin("COL", 1'b0, COL);
    TX_EN = 1'b0;
    wr(16'h0000);
    check_pin("ISOLATE", 1'b0, ISOLATE);
    wr(16'h1200);
    check_pin("AN_RESTART", 1'b1, AN_RESTART);
    rd(5'h00, 16'h1200);
    wr(16'h1000);
    rd(5'h00, 16'h1200);
    check_pin("AN_RESTART", 1'b1, AN_RESTART);
    AN_STARTED = 1'b1;
    @(posedge CLK);
    #1 AN_STARTED = 1'b0;
    settle();
    check_pin("AN_RESTART", 1'b0, AN_RESTART);
    rd(5'h00, 16'h1000);
    wr(16'h4800);
    check_pin("POWER_DOWN", 1'b1, POWER_DOWN);
    check_pin("ISOLATE", 1'b1, ISOLATE);
    check_pin("LOOPBACK", 1'b0, LOOPBACK);
    rd(5'h00, 16'h4800);
    wr(16'h0000);
    check_pin("POWER_DOWN", 1'b0, POWER_DOWN);
    SLEEP_REQUEST_PIN_N = 1'b0;
    settle();
    check_pin("POWER_DOWN", 1'b1, POWER_DOWN);
    SLEEP_REQUEST_PIN_N = 1'b1;
    settle();
    rd(5'h00, 16'h0800);
    check_pin("POWER_DOWN", 1'b1, POWER_DOWN);
    // ==========
    // Mid-run reset with other straps
    STRAP_AN_ENABLE = 1'b0;
    STRAP_SPEED_100 = 1'b0;
    RST_N = 1'b0;
    repeat (2) @(posedge CLK);
    #1 RST_N = 1'b1;
    settle();
    rd(5'h00, 16'h0100);
    check_pin("POWER_DOWN", 1'b0, POWER_DOWN);
    check_pin("FORCE_FULL_DUPLEX", 1'b1, FORCE_FULL_DUPLEX);
    check_pin("FORCE_SPEED_100", 1'b0, FORCE_SPEED_100);
    check_pin("AN_ENABLE", 1'b0, AN_ENABLE);
    wr(16'h0000);
    report_and_stop();
  end
endmodule : tb_phy_basic_control
